// File: logic/deep_sleep_pkg.sv
// Constants, register map and carrier types for the deep-sleep and thermal state controller.
// Assumes a single 125 MHz core clock and an 8-bit register port in front of the serial slave.
package deep_sleep_pkg;

  // Clock and timing
  localparam int unsigned CLK_FREQ_KHZ = 125000;
  localparam int unsigned PB_HOLD_MS = 32;
  localparam int unsigned PB_HOLD_CYCLES = PB_HOLD_MS * CLK_FREQ_KHZ;
  localparam int unsigned DELAY_STEP_US = 250;
  localparam int unsigned DELAY_STEP_CYCLES = (DELAY_STEP_US * CLK_FREQ_KHZ + 999) / 1000;

  // Sizes
  localparam int unsigned NUM_OUT = 5;
  localparam int unsigned NUM_RST = 2;
  localparam int unsigned DLY_W = 8;

  typedef logic [7:0] addr_t;
  typedef logic [7:0] data_t;

  // Register offsets
  localparam addr_t REG_CTRL = 8'h00;
  localparam addr_t REG_IRQ_MASK = 8'h01;
  localparam addr_t REG_IRQ_STATUS = 8'h02;
  localparam addr_t REG_STATE = 8'h03;
  localparam addr_t REG_DEEP_ON = 8'h04;
  localparam addr_t REG_SLEEP_ON = 8'h05;
  localparam addr_t REG_VSC_CFG = 8'h06;
  localparam addr_t REG_OUT_STATUS = 8'h07;
  localparam addr_t REG_ON_DLY_BASE = 8'h08;
  localparam addr_t REG_OFF_DLY_BASE = 8'h10;

  // Field positions
  localparam int unsigned CTRL_REQ_BIT = 0;
  localparam int unsigned CTRL_COMBINE_BIT = 1;
  localparam int unsigned CTRL_ENABLE_BIT = 2;
  localparam int unsigned IRQ_ENTER_BIT = 0;
  localparam int unsigned IRQ_EXIT_BIT = 1;
  localparam int unsigned IRQ_PB_BIT = 2;
  localparam int unsigned IRQ_THERMAL_BIT = 5;
  localparam int unsigned STATE_ACTIVE_BIT = 0;
  localparam int unsigned STATE_DEEP_BIT = 1;
  localparam int unsigned STATE_THERMAL_BIT = 2;
  localparam int unsigned VSC_ON_BIT = 0;

  // Values after reset
  localparam data_t CTRL_RESET = 8'h00;
  localparam data_t MASK_RESET = 8'h00;
  localparam data_t STATUS_RESET = 8'h00;
  localparam data_t DEEP_ON_RESET = 8'h00;
  localparam data_t SLEEP_ON_RESET = 8'h1F;
  localparam data_t VSC_RESET = 8'h00;
  localparam logic [DLY_W-1:0] DELAY_RESET = 8'h00;

  typedef enum logic [1:0] {ST_ACTIVE, ST_DEEP, ST_THERMAL} pm_state_e;

  typedef struct packed {
    addr_t addr;
    data_t wrData;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic combineSelect;
    logic gpioConfigured;
    logic [NUM_OUT-1:0] vinTrigger;
  } factory_cfg_s;

endpackage

// File: logic/deep_sleep_thermal_state_ctrl.sv
// Deep low-power and thermal state control with per-output sequencing and register port.
// Assumes factory configuration and voltage scaling request come from logic on core_clk;
// pushbutton, GPIO control and thermal comparator are asynchronous pins.
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/10ps

module deep_sleep_thermal_state_ctrl #(
  parameter int unsigned PB_HOLD = deep_sleep_pkg::PB_HOLD_CYCLES,
  parameter int unsigned DELAY_STEP = deep_sleep_pkg::DELAY_STEP_CYCLES,
  parameter int unsigned NUM_RST = deep_sleep_pkg::NUM_RST
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input deep_sleep_pkg::reg_req_s regReq,
  output deep_sleep_pkg::data_t rdData,
  input deep_sleep_pkg::factory_cfg_s factoryCfg,
  input wire logic pushbutton_n,
  input wire logic gpioCtrl,
  input wire logic thermalHot,
  input wire logic vscRequest,
  output logic [deep_sleep_pkg::NUM_OUT-1:0] regEnable,
  output logic [deep_sleep_pkg::NUM_OUT-1:0] sleepOnMask,
  output logic [NUM_RST-1:0] resetPins_n,
  output logic vscApply,
  output logic deepSleepActive,
  output logic irq
);
  import deep_sleep_pkg::*;

  // Decodes a window of per-output delay registers
  function automatic logic inWindow(input addr_t a, input addr_t base);
    inWindow = (a >= base) && (a < base + addr_t'(NUM_OUT));
  endfunction

  logic [1:0] pbSh, gpioSh, hotSh;
  pm_state_e state, next_state;
  logic dsReq, dsEnableField;
  data_t irqMask, irqStatus, next_status, deepOnMask, sleepOn, vscCfg, rdNext;
  logic [31:0] pbCount, stepCount;
  logic [DLY_W-1:0] onDly [NUM_OUT], offDly [NUM_OUT], dlyCnt [NUM_OUT];
  logic enArr [NUM_OUT], fastOn [NUM_OUT], delayDone [NUM_OUT], target [NUM_OUT];

  wire logic pbIdle = pbSh[1];
  wire logic gpioIn = gpioSh[1];
  wire logic hot = hotSh[1];

  // Two-stage synchronisers on asynchronous pins
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pbSh <= 2'h3;
      gpioSh <= 2'h0;
      hotSh <= 2'h0;
    end
    else
    begin
      pbSh <= {pbSh[0], pushbutton_n};
      gpioSh <= {gpioSh[0], gpioCtrl};
      hotSh <= {hotSh[0], thermalHot};
    end
  end

  // Register port decode; never gated by power state
  wire logic wrCtrl = regReq.wr && (regReq.addr == REG_CTRL);
  wire logic wrMask = regReq.wr && (regReq.addr == REG_IRQ_MASK);
  wire logic wrStatus = regReq.wr && (regReq.addr == REG_IRQ_STATUS);
  wire logic wrDeepOn = regReq.wr && (regReq.addr == REG_DEEP_ON);
  wire logic wrSleepOn = regReq.wr && (regReq.addr == REG_SLEEP_ON);
  wire logic wrVsc = regReq.wr && (regReq.addr == REG_VSC_CFG);
  wire logic wrOnDly = regReq.wr && inWindow(regReq.addr, REG_ON_DLY_BASE);
  wire logic wrOffDly = regReq.wr && inWindow(regReq.addr, REG_OFF_DLY_BASE);
  wire logic [2:0] onIdx = 3'(regReq.addr - REG_ON_DLY_BASE);
  wire logic [2:0] offIdx = 3'(regReq.addr - REG_OFF_DLY_BASE);

  // Entry condition; the enable field takes no part in it
  wire logic combined = factoryCfg.gpioConfigured
    ? (factoryCfg.combineSelect ? (dsReq | gpioIn) : (dsReq & gpioIn))
    : dsReq;
  wire logic enterCond = pbIdle & combined;

  // Pushbutton hold timer; saturates so the clear fires once per press
  wire logic pbLong = !pbIdle && (pbCount == PB_HOLD);
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || pbIdle)
      pbCount <= 32'h0;
    else if (pbCount <= PB_HOLD)
      pbCount <= pbCount + 32'h1;
  end

  // Sequencing step tick; delays carry up to one step of phase jitter
  wire logic tick = (stepCount == DELAY_STEP - 1);
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || tick)
      stepCount <= 32'h0;
    else
      stepCount <= stepCount + 32'h1;
  end

  // Power state selection; thermal overrides everything
  always_comb
  begin
    next_state = state;
    case (state)
      ST_ACTIVE:
        if (hot)
          next_state = ST_THERMAL;
        else if (enterCond)
          next_state = ST_DEEP;
      ST_DEEP:
        if (hot)
          next_state = ST_THERMAL;
        else if (!enterCond)
          next_state = ST_ACTIVE;
      ST_THERMAL:
        if (!hot)
          next_state = ST_ACTIVE;
      default:
        next_state = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      state <= ST_ACTIVE;
    else
      state <= next_state;
  end

  // Control register; the press clear beats a simultaneous write
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      dsReq <= CTRL_RESET[CTRL_REQ_BIT];
      dsEnableField <= CTRL_RESET[CTRL_ENABLE_BIT];
    end
    else
    begin
      if (pbLong)
        dsReq <= 1'b0;
      else if (wrCtrl)
        dsReq <= regReq.wrData[CTRL_REQ_BIT];
      if (wrCtrl)
        dsEnableField <= regReq.wrData[CTRL_ENABLE_BIT];
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      irqMask <= MASK_RESET;
      deepOnMask <= DEEP_ON_RESET;
      sleepOn <= SLEEP_ON_RESET;
      vscCfg <= VSC_RESET;
      for (int i = 0; i < NUM_OUT; i++)
      begin
        onDly[i] <= DELAY_RESET;
        offDly[i] <= DELAY_RESET;
      end
    end
    else
    begin
      if (wrMask)
        irqMask <= regReq.wrData;
      if (wrDeepOn)
        deepOnMask <= regReq.wrData;
      if (wrSleepOn)
        sleepOn <= regReq.wrData;
      if (wrVsc)
        vscCfg <= regReq.wrData;
      if (wrOnDly)
        onDly[onIdx] <= regReq.wrData;
      if (wrOffDly)
        offDly[offIdx] <= regReq.wrData;
    end
  end

  // Sticky events, write-one-to-clear; a new event wins over the clear
  wire data_t events = data_t'({
    2'h0, (next_state == ST_THERMAL) && (state != ST_THERMAL), 2'h0,
    pbLong,
    (state == ST_DEEP) && (next_state != ST_DEEP),
    (state != ST_DEEP) && (next_state == ST_DEEP)});
  assign next_status = (irqStatus & ~(wrStatus ? regReq.wrData : 8'h00)) | events;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      irqStatus <= STATUS_RESET;
    else
      irqStatus <= next_status;
  end
  // Mask only gates the line, never the state change
  assign irq = |(irqStatus & ~irqMask);

  // Per-output sequencer with programmed on and off delays
  for (genvar i = 0; i < NUM_OUT; i++)
  begin : g_seq
    assign target[i] = (state == ST_ACTIVE) || ((state == ST_DEEP) && deepOnMask[i]);
    assign delayDone[i] = dlyCnt[i] >= (target[i] ? onDly[i] : offDly[i]);
    assign regEnable[i] = enArr[i];

    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
      begin
        enArr[i] <= 1'b0;
        dlyCnt[i] <= DELAY_RESET;
      end
      else if (next_state == ST_THERMAL)
      begin
        enArr[i] <= 1'b0;
        dlyCnt[i] <= DELAY_RESET;
      end
      else if (enArr[i] == target[i])
        dlyCnt[i] <= DELAY_RESET;
      else if (fastOn[i] && target[i])
        enArr[i] <= 1'b1;
      else if (delayDone[i])
      begin
        enArr[i] <= target[i];
        dlyCnt[i] <= DELAY_RESET;
      end
      else if (tick)
        dlyCnt[i] <= dlyCnt[i] + 8'h01;
    end

    // Input-supply triggered outputs skip their delay once after cooling
    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
        fastOn[i] <= 1'b0;
      else if ((state == ST_THERMAL) && (next_state == ST_ACTIVE))
        fastOn[i] <= factoryCfg.vinTrigger[i];
      else if (enArr[i] || (state != ST_ACTIVE))
        fastOn[i] <= 1'b0;
    end

    AST_FAST_ON: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state == ST_THERMAL && next_state == ST_ACTIVE && factoryCfg.vinTrigger[i])
      |-> ##2 (enArr[i] || state != ST_ACTIVE))
      else $error("supply triggered output not on right after cooling");
    AST_DELAY_KEPT: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(enArr[i]) |-> ($past(fastOn[i]) || $past(delayDone[i])))
      else $error("output switched on before its delay ran out");
  end

  // Pin-facing outputs follow the next state so thermal acts at once
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      resetPins_n <= '0;
      vscApply <= 1'b0;
    end
    else
    begin
      resetPins_n <= {NUM_RST{next_state != ST_THERMAL}};
      vscApply <= vscRequest && vscCfg[VSC_ON_BIT] && (next_state == ST_ACTIVE);
    end
  end
  assign deepSleepActive = (state == ST_DEEP);
  assign sleepOnMask = sleepOn[NUM_OUT-1:0];

  // Read selection; combine-select reflects the factory image only
  always_comb
  begin
    rdNext = 8'h00;
    case (regReq.addr)
      REG_CTRL:
      begin
        rdNext[CTRL_REQ_BIT] = dsReq;
        rdNext[CTRL_COMBINE_BIT] = factoryCfg.combineSelect;
        rdNext[CTRL_ENABLE_BIT] = dsEnableField;
      end
      REG_IRQ_MASK: rdNext = irqMask;
      REG_IRQ_STATUS: rdNext = irqStatus;
      REG_STATE:
      begin
        rdNext[STATE_ACTIVE_BIT] = (state == ST_ACTIVE);
        rdNext[STATE_DEEP_BIT] = (state == ST_DEEP);
        rdNext[STATE_THERMAL_BIT] = (state == ST_THERMAL);
      end
      REG_DEEP_ON: rdNext = deepOnMask;
      REG_SLEEP_ON: rdNext = sleepOn;
      REG_VSC_CFG: rdNext = vscCfg;
      REG_OUT_STATUS: rdNext[NUM_OUT-1:0] = regEnable;
      default:
        if (inWindow(regReq.addr, REG_ON_DLY_BASE))
          rdNext = onDly[onIdx];
        else if (inWindow(regReq.addr, REG_OFF_DLY_BASE))
          rdNext = offDly[offIdx];
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      rdData <= 8'h00;
    else
      rdData <= regReq.rd ? rdNext : 8'h00;
  end

  // Checks on the state control
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence sActiveCool;
    state == ST_ACTIVE && !hot;
  endsequence
  sequence sThermalCool;
    state == ST_THERMAL && !hot;
  endsequence

  AST_COMBINE_RO: assert property (regReq.rd && regReq.addr == REG_CTRL
    |=> rdData[CTRL_COMBINE_BIT] == $past(factoryCfg.combineSelect))
    else $error("combine select does not read back the factory value");
  AST_OR_ENTRY: assert property (sActiveCool ##0 (pbIdle && factoryCfg.gpioConfigured
    && factoryCfg.combineSelect && (dsReq || gpioIn)) |=> state == ST_DEEP)
    else $error("OR combination did not enter deep sleep");
  AST_AND_BLOCK: assert property ((state == ST_ACTIVE && factoryCfg.gpioConfigured
    && !factoryCfg.combineSelect && !(dsReq && gpioIn)) |=> state != ST_DEEP)
    else $error("AND combination entered deep sleep with one input low");
  AST_SW_ONLY: assert property (sActiveCool ##0 (pbIdle && !factoryCfg.gpioConfigured)
    |=> (state == ST_DEEP) == $past(dsReq))
    else $error("without GPIO entry did not follow the request bit");
  AST_EXIT: assert property ((state == ST_DEEP && !hot && !enterCond) |=> state == ST_ACTIVE)
    else $error("deep sleep not left when condition went false");
  AST_PB_CLEAR: assert property (pbLong |=> (!dsReq && state != ST_DEEP) [*2])
    else $error("long press did not clear the request");
  AST_THERMAL_IN: assert property ((hot && state != ST_THERMAL) |=> state == ST_THERMAL)
    else $error("over temperature did not enter thermal state");
  AST_THERMAL_OFF: assert property (state == ST_THERMAL
    |-> (regEnable == '0 && resetPins_n == '0))
    else $error("thermal state left an output on or a reset high");
  AST_THERMAL_MASK: assert property ((state == ST_ACTIVE && hot && irqMask[IRQ_THERMAL_BIT]
    && (irqStatus & ~irqMask) == 8'h00 && !wrMask && !pbLong) |=> (state == ST_THERMAL && !irq))
    else $error("thermal mask blocked the state or let the interrupt through");
  AST_THERMAL_OUT: assert property (sThermalCool |=> state == ST_ACTIVE)
    else $error("cooled die did not return straight to active");
  AST_NO_VSC: assert property (state == ST_DEEP |-> !vscApply)
    else $error("voltage scaling applied in deep sleep");
  AST_PB_BLOCK: assert property ((!pbIdle && state == ST_ACTIVE) |=> state != ST_DEEP)
    else $error("deep sleep entered with pushbutton pressed");

endmodule // deep_sleep_thermal_state_ctrl

// File: bench/host_pin_model.sv
// Far-side pin model: host GPIO control, pushbutton and die temperature sensor.
// Assumes the bench sets wanted levels on core_clk; pins move one edge later.
`timescale 1ns/10ps
module host_pin_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wantGpio,
  input wire logic wantPress,
  input wire logic wantHot,
  output logic gpioCtrl,
  output logic pushbutton_n,
  output logic thermalHot
);
  // Pins change only after an edge, like a real slow host; button reads released in reset
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      gpioCtrl <= 1'b0;
      pushbutton_n <= 1'b1;
      thermalHot <= 1'b0;
    end
    else
    begin
      gpioCtrl <= wantGpio;
      pushbutton_n <= !wantPress; // Active low pin
      thermalHot <= wantHot;
    end
  end
endmodule // host_pin_model

// File: bench/tb_deep_sleep_thermal_state_ctrl.sv
// Self-checking bench for the deep-sleep and thermal state controller.
// Assumes short sim counts: pushbutton hold 20 cycles, delay step 4 cycles.
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module tb_deep_sleep_thermal_state_ctrl;
  import deep_sleep_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  reg_req_s regReq = '0;
  factory_cfg_s factoryCfg = '0;
  logic vscRequest = 1'b0;
  logic wantGpio = 1'b0;
  logic wantPress = 1'b0;
  logic wantHot = 1'b0;
  logic gpioCtrl, pushbutton_n, thermalHot, vscApply, deepSleepActive, irq;
  logic [NUM_OUT-1:0] regEnable, sleepOnMask, mask, vin;
  logic [1:0] resetPins_n;
  data_t rdData, got;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  deep_sleep_thermal_state_ctrl #(.PB_HOLD(20), .DELAY_STEP(4), .NUM_RST(2)) dut_u (.core_clk(core_clk),
    .rst_n(rst_n), .regReq(regReq), .rdData(rdData), .factoryCfg(factoryCfg), .pushbutton_n(pushbutton_n),
    .gpioCtrl(gpioCtrl), .thermalHot(thermalHot), .vscRequest(vscRequest), .regEnable(regEnable),
    .sleepOnMask(sleepOnMask), .resetPins_n(resetPins_n), .vscApply(vscApply),
    .deepSleepActive(deepSleepActive), .irq(irq));
  host_pin_model pins_u (.core_clk(core_clk), .rst_n(rst_n), .wantGpio(wantGpio), .wantPress(wantPress),
    .wantHot(wantHot), .gpioCtrl(gpioCtrl), .pushbutton_n(pushbutton_n), .thermalHot(thermalHot));

  // 125 MHz core clock
  initial
  begin
    forever #4 core_clk = !core_clk;
  end

  // Hang guard; a full run needs about 440 cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checked %0d values, %0d mismatches", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Wait n edges, then step past them so outputs are settled
  task automatic waitc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Single-cycle write strobe
  task automatic wr(input addr_t a, input data_t d);
    @(posedge core_clk);
    regReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    regReq.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input addr_t a, output data_t d);
    @(posedge core_clk);
    regReq <= '{addr: a, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    regReq.rd <= 1'b0;
    #1;
    d = rdData;
  endtask

  // Expected entry condition from the truth tables
  function automatic logic entry_exp(input logic c, input logic g, input logic r, input logic p);
    if (!g)
      return r;
    return c ? (r | p) : (r & p);
  endfunction

  // Main sequence
  initial
  begin
    void'($urandom(32'hB492));
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    waitc(2);
    // Reset values and unmapped place
    rd(REG_CTRL, got); `CHK(got, CTRL_RESET)
    rd(REG_STATE, got); `CHK(got, 8'h01)
    rd(REG_SLEEP_ON, got); `CHK(got, SLEEP_ON_RESET)
    rd(8'h3F, got); `CHK(got, 8'h00)
    `CHK(resetPins_n, 2'h3)
    $display("test reset done");

    // Every combination of combine, GPIO use, request and GPIO level
    for (int i = 0; i < 16; i++)
    begin
      @(posedge core_clk);
      factoryCfg.combineSelect <= i[3];
      factoryCfg.gpioConfigured <= i[2];
      wantGpio <= i[0];
      wr(REG_CTRL, {5'h00, 1'($urandom), !i[3], i[1]}); // Try to flip combine, random enable field
      waitc(6);
      `CHK(deepSleepActive, entry_exp(i[3], i[2], i[1], i[0]))
      rd(REG_CTRL, got); `CHK(got[CTRL_COMBINE_BIT], i[3])
      rd(REG_STATE, got); `CHK(got[STATE_DEEP_BIT], deepSleepActive)
    end
    wr(REG_CTRL, 8'h00);
    factoryCfg <= '0;
    $display("test entry table done");

    // Deep-sleep output mask, delays, and no scaling in deep sleep
    mask = 5'($urandom) & 5'h1E;
    wr(REG_DEEP_ON, {3'h0, mask});
    for (int k = 0; k < NUM_OUT; k++)
      wr(REG_OFF_DLY_BASE + 8'(k), 8'h03);
    wr(REG_VSC_CFG, 8'h01);
    vscRequest <= 1'b1;
    wr(REG_IRQ_STATUS, 8'hFF);
    wr(REG_CTRL, 8'h01);
    waitc(3);
    `CHK(regEnable, 5'h1F)
    `CHK(irq, 1'b1)
    waitc(30);
    `CHK(regEnable, mask)
    `CHK(sleepOnMask, 5'h1F)
    `CHK(vscApply, 1'b0)
    wr(REG_CTRL, 8'h00);
    waitc(30);
    `CHK(regEnable, 5'h1F)
    `CHK(vscApply, 1'b1)
    $display("test deep outputs done");

    // Long press while in deep sleep clears the request
    wr(REG_CTRL, 8'h01);
    waitc(4);
    @(posedge core_clk);
    wantPress <= 1'b1;
    waitc(4);
    `CHK(deepSleepActive, 1'b0)
    waitc(30);
    @(posedge core_clk);
    wantPress <= 1'b0;
    waitc(5);
    rd(REG_CTRL, got); `CHK(got[CTRL_REQ_BIT], 1'b0)
    `CHK(deepSleepActive, 1'b0)
    rd(REG_IRQ_STATUS, got); `CHK(got[IRQ_PB_BIT], 1'b1)
    $display("test long press done");

    // Thermal entry with interrupt masked, then cool-down return
    vin = 5'($urandom);
    @(posedge core_clk);
    factoryCfg.vinTrigger <= vin;
    for (int k = 0; k < NUM_OUT; k++)
      wr(REG_ON_DLY_BASE + 8'(k), 8'h05);
    wr(REG_IRQ_STATUS, 8'hFF);
    wr(REG_IRQ_MASK, 8'h20);
    wantHot <= 1'b1;
    waitc(6);
    `CHK(regEnable, 5'h00)
    `CHK(resetPins_n, 2'h0)
    `CHK(irq, 1'b0)
    rd(REG_STATE, got); `CHK(got, 8'h04)
    wr(REG_IRQ_MASK, 8'h00);
    waitc(1);
    `CHK(irq, 1'b1)
    @(posedge core_clk);
    wantHot <= 1'b0;
    waitc(7);
    `CHK(regEnable, vin)
    rd(REG_STATE, got); `CHK(got, 8'h01)
    waitc(40);
    `CHK(regEnable, 5'h1F)
    `CHK(resetPins_n, 2'h3)
    wr(REG_IRQ_STATUS, 8'hFF);
    waitc(1);
    `CHK(irq, 1'b0)
    $display("test thermal done");
    finish_test();
  end
endmodule // tb_deep_sleep_thermal_state_ctrl
